//--- design/cmel_consts.vh
`ifndef CMEL_CONSTS_VH
`define CMEL_CONSTS_VH
// APB map: each channel owns a 0x20 byte window, the global control word sits above.
`define CMEL_CH_STRIDE    8'h20
`define CMEL_OFF_STATUS   5'h00
`define CMEL_OFF_GMASK    5'h04
`define CMEL_OFF_MBMASK   5'h08
`define CMEL_OFF_DFPEND   5'h0C
`define CMEL_OFF_RFPEND   5'h10
`define CMEL_OFF_TXDONE   5'h14
`define CMEL_OFF_ABDONE   5'h18
`define CMEL_OFF_STATE    5'h1C
`define CMEL_ADDR_CTRL    8'h40
// Control word fields.
`define CMEL_CTRL_DMA_EN  0
`define CMEL_CTRL_COMB    1
`define CMEL_CTRL_RST0    2
`define CMEL_CTRL_RST1    3
// Interrupt status bit positions.
`define CMEL_ST_POR       0
`define CMEL_ST_DFRX      1
`define CMEL_ST_RFRX      2
`define CMEL_ST_TXWARN    3
`define CMEL_ST_RXWARN    4
`define CMEL_ST_PASSIVE   5
`define CMEL_ST_BUSOFF    6
`define CMEL_ST_EMPTY     8
`define CMEL_ST_WAKE      12
// Vector groups.
`define CMEL_ERR_GROUP    16'h0078
`define CMEL_OVR_GROUP    16'hFE81
`define CMEL_MISC_EVENTS  16'hEE81
// Reset values.
`define CMEL_GMASK_RST    16'hFFFF
`define CMEL_MBMASK_RST   32'hFFFF_FFFF
`define CMEL_CTRL_RST     4'h0
// Error counter thresholds.
`define CMEL_WARN_LIMIT   9'h060
`define CMEL_PASSIVE_LIM  9'h080
`define CMEL_BUSOFF_LIM   9'h100
`define CMEL_RECOV_COUNT  8'h80
`endif

//--- design/cmel_event_logic.v
`timescale 1ns/100ps
`include "cmel_consts.vh"

module cmel_event_logic (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire [17:0] tx_err_count,
    input  wire [17:0] rx_err_count,
    input  wire [1:0]  recessive_run,
    input  wire [1:0]  sleep_mode,
    input  wire [1:0]  can_rx_pin,
    input  wire [31:0] misc_events,
    input  wire [1:0]  rx_data_frame,
    input  wire [1:0]  rx_remote_frame,
    input  wire [9:0]  rx_mailbox,
    input  wire [63:0] transmit_done_in,
    input  wire [63:0] abort_done_in,
    input  wire [63:0] transmit_request_flags,
    input  wire        dma_done,
    output wire        dma_request,
    output wire [1:0]  error_vector,
    output wire [1:0]  overrun_group_vector,
    output wire [1:0]  receive_vector,
    output wire [1:0]  mailbox_empty_vector,
    output wire [1:0]  bus_off,
    output wire [1:0]  soft_reset_bit,
    output wire        combined_mode,
    output wire [9:0]  tx_select,
    output wire [1:0]  tx_select_valid
);

    reg  [3:0]  ctrl_q;
    reg         rd_err;
    reg  [31:0] rd_word;
    wire        setup;
    wire        wr_acc;
    wire        dma_en;
    wire [63:0] rd_ch;
    wire [1:0]  hit_ch;
    wire [1:0]  vec_rx_raw;
    wire [1:0]  vec_empty_raw;

    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = rd_err & psel & penable;
    assign dma_en  = ctrl_q[`CMEL_CTRL_DMA_EN];
    assign combined_mode  = ctrl_q[`CMEL_CTRL_COMB];
    assign soft_reset_bit = {ctrl_q[`CMEL_CTRL_RST1], ctrl_q[`CMEL_CTRL_RST0]};

    // In the combined arrangement both channels sit on one bus, so their receive and
    // empty events are presented on channel 0 as one 64-buffer channel.
    assign receive_vector       = combined_mode ? {1'b0, |vec_rx_raw} : vec_rx_raw;
    assign mailbox_empty_vector = combined_mode ? {1'b0, |vec_empty_raw} : vec_empty_raw;

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            ctrl_q <= `CMEL_CTRL_RST;
        else if (wr_acc && paddr == `CMEL_ADDR_CTRL)
            ctrl_q <= pwdata[3:0];
    end

    // Read data is captured in the setup cycle, so every access completes with no wait.
    always @*
    begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (paddr == `CMEL_ADDR_CTRL)
            rd_word = {28'h000_0000, ctrl_q};
        else if (hit_ch[0])
            rd_word = rd_ch[31:0];
        else if (hit_ch[1])
            rd_word = rd_ch[63:32];
        else
            rd_err = 1'b1;
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_word;
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_ch
            reg  [15:0] st_q;
            reg  [15:0] gmask_q;
            reg  [31:0] mbmask_q;
            reg  [31:0] dfp_q;
            reg  [31:0] rfp_q;
            reg  [31:0] txd_q;
            reg  [31:0] abd_q;
            reg  [2:0]  pin_q;
            reg         pin_stable_q;
            reg         boff_q;
            reg  [7:0]  recov_q;
            reg  [3:0]  lvl_q;
            reg  [4:0]  sel_d;
            reg         selv_d;
            integer     k;
            wire        crst;
            wire [4:0]  mb;
            wire [31:0] mb_bit;
            wire [31:0] dma_owned;
            wire [3:0]  lvl_d;
            wire [15:0] st_set;
            wire [15:0] st_clr;
            wire [15:0] st_live;
            wire        recov_done;
            wire        wake;
            wire        reg_wr;
            wire [4:0]  off;
            wire [31:0] tx_req;
            wire [31:0] wmask;

            assign crst   = ~rst_n | ctrl_q[`CMEL_CTRL_RST0 + ch];
            assign off    = paddr[4:0];
            assign hit_ch[ch] = (paddr[7:5] == ch);
            assign reg_wr = wr_acc & hit_ch[ch];
            assign wmask  = reg_wr ? pwdata : 32'h0000_0000;
            assign mb     = rx_mailbox[ch*5 +: 5];
            assign mb_bit = 32'h0000_0001 << mb;
            assign tx_req = transmit_request_flags[ch*32 +: 32];

            // Threshold levels; warning and passive flags are set on the rising crossing only, bus off also when recovery ends.
            assign lvl_d[0] = tx_err_count[ch*9 +: 9] >= `CMEL_WARN_LIMIT;
            assign lvl_d[1] = rx_err_count[ch*9 +: 9] >= `CMEL_WARN_LIMIT;
            assign lvl_d[2] = (tx_err_count[ch*9 +: 9] >= `CMEL_PASSIVE_LIM)
                            | (rx_err_count[ch*9 +: 9] >= `CMEL_PASSIVE_LIM);
            assign lvl_d[3] = tx_err_count[ch*9 +: 9] >= `CMEL_BUSOFF_LIM;
            assign recov_done = boff_q & recessive_run[ch]
                              & (recov_q == `CMEL_RECOV_COUNT - 8'h01);
            assign wake = sleep_mode[ch] & pin_stable_q
                        & (pin_q[1] == pin_q[2]) & ~pin_q[2];

            // Status bits: the event always sets the flag, whatever any mask says.
            assign st_set = (misc_events[ch*16 +: 16] & `CMEL_MISC_EVENTS)
                          | ({15'h0000, rx_data_frame[ch]} << `CMEL_ST_DFRX)
                          | ({15'h0000, rx_remote_frame[ch]} << `CMEL_ST_RFRX)
                          | ({15'h0000, lvl_d[0] & ~lvl_q[0]} << `CMEL_ST_TXWARN)
                          | ({15'h0000, lvl_d[1] & ~lvl_q[1]} << `CMEL_ST_RXWARN)
                          | ({15'h0000, lvl_d[2] & ~lvl_q[2]} << `CMEL_ST_PASSIVE)
                          | ({15'h0000, (lvl_d[3] & ~boff_q) | recov_done}
                                << `CMEL_ST_BUSOFF)
                          | ({15'h0000, |(transmit_done_in[ch*32 +: 32]
                                | abort_done_in[ch*32 +: 32])} << `CMEL_ST_EMPTY)
                          | ({15'h0000, wake} << `CMEL_ST_WAKE);
            assign st_clr = (reg_wr && off == `CMEL_OFF_STATUS) ? pwdata[15:0] : 16'h0000;
            assign st_live = st_q & ~gmask_q;

            // Mailbox 0 of channel 0 belongs to the DMA once activation is configured.
            assign dma_owned = (ch == 0 && dma_en) ? 32'h0000_0001 : 32'h0000_0000;

            always @(posedge sys_clk)
            begin
                if (crst)
                begin
                    st_q     <= 16'h0000;
                    gmask_q  <= `CMEL_GMASK_RST;
                    mbmask_q <= `CMEL_MBMASK_RST;
                    dfp_q    <= 32'h0000_0000;
                    rfp_q    <= 32'h0000_0000;
                    txd_q    <= 32'h0000_0000;
                    abd_q    <= 32'h0000_0000;
                    boff_q   <= 1'b0;
                    recov_q  <= 8'h00;
                    lvl_q    <= 4'h0;
                end
                else
                begin
                    // A set in the same cycle as a write-one clear wins.
                    st_q  <= (st_q & ~st_clr) | st_set;
                    lvl_q <= lvl_d;
                    if (reg_wr && off == `CMEL_OFF_GMASK)
                        gmask_q <= pwdata[15:0];
                    if (reg_wr && off == `CMEL_OFF_MBMASK)
                        mbmask_q <= pwdata;
                    dfp_q <= (dfp_q & ~(off == `CMEL_OFF_DFPEND ? wmask : 32'h0000_0000)
                              & ~((ch == 0 && dma_en && dma_done) ? 32'h0000_0001
                                  : 32'h0000_0000))
                           | (rx_data_frame[ch] ? mb_bit : 32'h0000_0000);
                    rfp_q <= (rfp_q & ~(off == `CMEL_OFF_RFPEND ? wmask : 32'h0000_0000)
                              & ~((ch == 0 && dma_en && dma_done) ? 32'h0000_0001
                                  : 32'h0000_0000))
                           | (rx_remote_frame[ch] ? mb_bit : 32'h0000_0000);
                    txd_q <= (txd_q & ~(off == `CMEL_OFF_TXDONE ? wmask : 32'h0000_0000))
                           | transmit_done_in[ch*32 +: 32];
                    abd_q <= (abd_q & ~(off == `CMEL_OFF_ABDONE ? wmask : 32'h0000_0000))
                           | abort_done_in[ch*32 +: 32];
                    // Recovery counts 128 runs of eleven recessive bits while off the bus.
                    if (lvl_d[3] && !boff_q)
                    begin
                        boff_q  <= 1'b1;
                        recov_q <= 8'h00;
                    end
                    else if (recov_done)
                        boff_q <= 1'b0;
                    else if (boff_q && recessive_run[ch])
                        recov_q <= recov_q + 8'h01;
                end
            end

            // The bus pin is asynchronous; a level is accepted once stages two and three agree.
            always @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    pin_q        <= 3'b111;
                    pin_stable_q <= 1'b1;
                end
                else
                begin
                    pin_q <= {pin_q[1:0], can_rx_pin[ch]};
                    if (pin_q[1] == pin_q[2])
                        pin_stable_q <= pin_q[2];
                end
            end

            // Mailbox 0 only receives, so buffers 1 to 31 compete, lowest number first.
            // Each channel decides alone; no priority is resolved across the pair.
            always @*
            begin
                sel_d  = 5'h00;
                selv_d = 1'b0;
                for (k = 31; k >= 1; k = k - 1)
                begin
                    if (tx_req[k])
                    begin
                        sel_d  = k[4:0];
                        selv_d = 1'b1;
                    end
                end
            end

            assign tx_select[ch*5 +: 5] = sel_d;
            assign tx_select_valid[ch]  = selv_d & ~ctrl_q[`CMEL_CTRL_RST0 + ch];
            assign bus_off[ch]          = boff_q;

            assign error_vector[ch] = |(st_live & `CMEL_ERR_GROUP);
            assign overrun_group_vector[ch] = |(st_live & `CMEL_OVR_GROUP);
            // Only pending mailboxes that are unmasked and not DMA-owned raise the vector.
            assign vec_rx_raw[ch] =
                (st_live[`CMEL_ST_DFRX] & |(dfp_q & ~mbmask_q & ~dma_owned))
              | (st_live[`CMEL_ST_RFRX] & |(rfp_q & ~mbmask_q & ~dma_owned));
            assign vec_empty_raw[ch] = st_live[`CMEL_ST_EMPTY]
                                     & |((txd_q | abd_q) & ~mbmask_q);

            assign rd_ch[ch*32 +: 32] =
                (off == `CMEL_OFF_STATUS) ? {16'h0000, st_q} :
                (off == `CMEL_OFF_GMASK)  ? {16'h0000, gmask_q} :
                (off == `CMEL_OFF_MBMASK) ? mbmask_q :
                (off == `CMEL_OFF_DFPEND) ? dfp_q :
                (off == `CMEL_OFF_RFPEND) ? rfp_q :
                (off == `CMEL_OFF_TXDONE) ? txd_q :
                (off == `CMEL_OFF_ABDONE) ? abd_q :
                {28'h000_0000, lvl_q[2], boff_q, sleep_mode[ch], pin_stable_q};
        end
    endgenerate

    // Only channel 0 mailbox 0 may ask the DMA; every other source is excluded.
    assign dma_request = dma_en & ~ctrl_q[`CMEL_CTRL_RST0]
                       & (g_ch[0].dfp_q[0] | g_ch[0].rfp_q[0]);

endmodule // cmel_event_logic

//--- test/cmel_bus_node.sv
`timescale 1ns/100ps
module cmel_bus_node (
    input  wire         sys_clk,
    output logic [17:0] tx_err_count,
    output logic [17:0] rx_err_count,
    output logic [1:0]  recessive_run,
    output logic [1:0]  can_rx_pin
);
    // The bus idles recessive, which is the high level on the receive pin.
    initial
    begin
        tx_err_count = 18'h0;
        rx_err_count = 18'h0;
        recessive_run = 2'h0;
        can_rx_pin = 2'h3;
    end
    task set_err(input int ch, input logic [8:0] t, input logic [8:0] r);
        @(posedge sys_clk);
        tx_err_count[ch*9+:9] <= t;
        rx_err_count[ch*9+:9] <= r;
    endtask
    task recessive(input int ch, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            recessive_run[ch] <= 1'b1;
            @(posedge sys_clk);
            recessive_run[ch] <= 1'b0;
        end
    endtask
    task activity(input int ch, input int n);
        @(posedge sys_clk);
        can_rx_pin[ch] <= 1'b0;
        repeat (n) @(posedge sys_clk);
        can_rx_pin[ch] <= 1'b1;
    endtask
endmodule // cmel_bus_node

//--- test/cmel_checker_properties.sv
`timescale 1ns/100ps
`include "cmel_consts.vh"
module cmel_checker (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire [17:0] tx_err_count,
    input wire [1:0]  recessive_run,
    input wire [1:0]  rx_data_frame,
    input wire [1:0]  rx_remote_frame,
    input wire [9:0]  rx_mailbox,
    input wire [63:0] transmit_request_flags,
    input wire        dma_done,
    input wire        dma_request,
    input wire [1:0]  error_vector,
    input wire [1:0]  receive_vector,
    input wire [1:0]  mailbox_empty_vector,
    input wire [1:0]  bus_off,
    input wire [1:0]  soft_reset_bit,
    input wire        combined_mode,
    input wire [9:0]  tx_select,
    input wire [1:0]  tx_select_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire rx0 = (rx_data_frame[0] | rx_remote_frame[0]) & (rx_mailbox[4:0] == 5'h0);
    wire ctl = psel & penable & (paddr == `CMEL_ADDR_CTRL);
    sequence dma_cause;
        $past(rx0) || $past(ctl);
    endsequence
    // Bus off falls at the edge that takes the last run; the deeper sample is a spare.
    sequence bus_off_release;
        $past(soft_reset_bit[0]) || $past(recessive_run[0]) || $past(recessive_run[0], 2);
    endsequence
    dma_source_a: assert property ($rose(dma_request) |-> dma_cause)
        else $error("dma request without a mailbox 0 reception");
    dma_clear_a: assert property (dma_done && !rx0 |=> !dma_request)
        else $error("dma request stays after transfer end");
    busoff_entry_a: assert property ($rose(tx_err_count[8]) && !soft_reset_bit[0]
        && !ctl |=> bus_off[0])
        else $error("bus off not entered at count 256");
    busoff_exit_a: assert property ($fell(bus_off[0]) |-> bus_off_release)
        else $error("bus off left without recovery");
    combined_vec_a: assert property (combined_mode
        |-> !receive_vector[1] && !mailbox_empty_vector[1])
        else $error("second vector active in combined mode");
    tx_owner_a: assert property (tx_select_valid[0] |-> !soft_reset_bit[0]
        && transmit_request_flags[tx_select[4:0]] && tx_select[4:0] != 5'h0)
        else $error("selected mailbox not pending");
    tx_lowest_a: assert property (tx_select_valid[1]
        |-> (transmit_request_flags[63:32] & ((32'h1 << tx_select[9:5]) - 32'h2)) == 32'h0)
        else $error("selected mailbox not the lowest pending");
    reset_quiet_a: assert property ($rose(rst_n) |-> error_vector == 2'h0
        && bus_off == 2'h0 && !dma_request)
        else $error("outputs active after reset");
endmodule // cmel_checker
bind cmel_event_logic cmel_checker cmel_checker_i (.sys_clk, .rst_n, .psel, .penable,
    .paddr, .tx_err_count, .recessive_run, .rx_data_frame, .rx_remote_frame, .rx_mailbox,
    .transmit_request_flags, .dma_done, .dma_request, .error_vector, .receive_vector,
    .mailbox_empty_vector, .bus_off, .soft_reset_bit, .combined_mode, .tx_select,
    .tx_select_valid);

//--- test/tb_cmel_event_logic.sv
`timescale 1ns/100ps
`include "cmel_consts.vh"
module tb_cmel_event_logic;
    logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        dma_done = 1'b0, pready, pslverr, dma_request, combined_mode, e, v;
    logic [4:0]  s;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, q, misc_events = 32'h0, exp_st, seed = 32'h31f1;
    logic [1:0]  sleep_mode = 2'h0, rx_data_frame = 2'h0, rx_remote_frame = 2'h0;
    logic [1:0]  can_rx_pin, recessive_run, error_vector, overrun_group_vector;
    logic [1:0]  receive_vector, mailbox_empty_vector, bus_off, soft_reset_bit;
    logic [1:0]  tx_select_valid;
    logic [9:0]  rx_mailbox = 10'h0, tx_select;
    logic [17:0] tx_err_count, rx_err_count;
    logic [63:0] transmit_done_in = 64'h0, abort_done_in = 64'h0, transmit_request_flags = 64'h0;
    int          err_count = 0, checks_done = 0, cyc = 0, m;
    int          tecs[4] = '{96, 96, 128, 256};
    int          recs[4] = '{0, 96, 96, 96};
    cmel_event_logic cmel_event_logic_i (.*);
    cmel_bus_node cmel_bus_node_i (.*);
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string n, input logic [63:0] x, input logic [63:0] g);
        checks_done++;
        if (g !== x)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, x, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("rdata", x, q);
        chk("pslverr", a[1:0] != 2'h0 || a > 8'h40, e);
    endtask
    task rx(input int ch, input int mb, input int k);
        @(posedge sys_clk);
        rx_mailbox[ch*5+:5] <= mb[4:0];
        if (k != 0)
            rx_remote_frame[ch] <= 1'b1;
        else
            rx_data_frame[ch] <= 1'b1;
        @(posedge sys_clk);
        rx_remote_frame <= 2'h0;
        rx_data_frame <= 2'h0;
        #1;
    endtask
    task end_of_test();
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`CMEL_OFF_GMASK, 32'hFFFF);
        rd(`CMEL_OFF_MBMASK, 32'hFFFF_FFFF);
        rd(8'h44, 32'h0);
        wr(`CMEL_OFF_GMASK, 32'hFFF9);
        for (int k = 0; k < 2; k++)
        begin
            m = 1 + rnd() % 31;
            rx(0, m, k);
            chk("rxvec", 0, receive_vector[0]);
            rd(`CMEL_OFF_STATUS, 32'h1 << (k + 1));
            rd(`CMEL_OFF_DFPEND + 4 * k, 32'h1 << m);
            wr(`CMEL_OFF_MBMASK, ~(32'h1 << m));
            chk("rxvec", 1, receive_vector[0]);
            wr(`CMEL_OFF_STATUS, 32'h6);
            wr(`CMEL_OFF_DFPEND + 4 * k, 32'hFFFF_FFFF);
            chk("rxvec", 0, receive_vector[0]);
            wr(`CMEL_OFF_MBMASK, 32'hFFFF_FFFF);
        end
        wr(`CMEL_OFF_GMASK, 32'hFF87);
        exp_st = 0;
        for (int i = 0; i < 4; i++)
        begin
            cmel_bus_node_i.set_err(0, tecs[i], recs[i]);
            exp_st |= (tecs[i] > 95) * 8 | (recs[i] > 95) * 16 | (tecs[i] > 127) * 32;
            exp_st |= (recs[i] > 127) * 32 | (tecs[i] > 255) * 64;
            repeat (2) @(posedge sys_clk);
            rd(`CMEL_OFF_STATUS, exp_st);
            chk("errvec", 1, error_vector[0]);
        end
        chk("busoff", 1, bus_off[0]);
        chk("dma", 0, dma_request);
        cmel_bus_node_i.set_err(0, 0, 0);
        wr(`CMEL_OFF_STATUS, 32'hFFFF);
        chk("errvec", 0, error_vector[0]);
        cmel_bus_node_i.recessive(0, 127);
        rd(`CMEL_OFF_STATUS, 32'h0);
        cmel_bus_node_i.recessive(0, 1);
        repeat (2) @(posedge sys_clk);
        rd(`CMEL_OFF_STATUS, 32'h40);
        chk("busoff", 0, bus_off[0]);
        wr(`CMEL_OFF_STATUS, 32'hFFFF);
        wr(`CMEL_OFF_GMASK, ~`CMEL_OVR_GROUP);
        for (int b = 0; b < 16; b++)
            if (`CMEL_MISC_EVENTS >> b & 1)
            begin
                @(posedge sys_clk);
                misc_events[b] <= 1'b1;
                @(posedge sys_clk);
                misc_events <= 32'h0;
                #1;
                chk("ovrvec", 1, overrun_group_vector[0]);
                rd(`CMEL_OFF_STATUS, 32'h1 << b);
                wr(`CMEL_OFF_STATUS, 32'hFFFF);
                chk("ovrvec", 0, overrun_group_vector[0]);
            end
        @(posedge sys_clk);
        sleep_mode <= 2'h1;
        cmel_bus_node_i.activity(0, 8);
        rd(`CMEL_OFF_STATUS, 32'h1000);
        chk("ovrvec", 1, overrun_group_vector[0]);
        @(posedge sys_clk);
        sleep_mode <= 2'h0;
        wr(`CMEL_OFF_STATUS, 32'hFFFF);
        wr(`CMEL_OFF_GMASK, 32'hFEFF);
        for (int k = 0; k < 2; k++)
        begin
            m = rnd() % 32;
            wr(`CMEL_OFF_MBMASK, ~(32'h1 << m));
            @(posedge sys_clk);
            if (k != 0)
                abort_done_in[m] <= 1'b1;
            else
                transmit_done_in[m] <= 1'b1;
            @(posedge sys_clk);
            abort_done_in <= 64'h0;
            transmit_done_in <= 64'h0;
            #1;
            chk("empvec", 1, mailbox_empty_vector[0]);
            rd(`CMEL_OFF_STATUS, 32'h100);
            rd(`CMEL_OFF_TXDONE + 4 * k, 32'h1 << m);
            wr(`CMEL_OFF_STATUS, 32'hFFFF);
            wr(`CMEL_OFF_TXDONE + 4 * k, 32'hFFFF_FFFF);
            chk("empvec", 0, mailbox_empty_vector[0]);
        end
        wr(`CMEL_OFF_GMASK, 32'hFFF9);
        wr(`CMEL_OFF_MBMASK, 32'hFFFF_FFFE);
        wr(`CMEL_ADDR_CTRL, 32'h1);
        rx(0, 0, 0);
        chk("dma", 1, dma_request);
        chk("rxvec", 0, receive_vector[0]);
        @(posedge sys_clk);
        dma_done <= 1'b1;
        @(posedge sys_clk);
        dma_done <= 1'b0;
        #1;
        chk("dma", 0, dma_request);
        rd(`CMEL_OFF_DFPEND, 32'h0);
        rd(`CMEL_OFF_STATUS, 32'h2);
        rx(1, 0, 0);
        chk("dma", 0, dma_request);
        wr(8'h24, 32'hFFF9);
        wr(8'h28, 32'hFFFF_FFFE);
        wr(`CMEL_ADDR_CTRL, 32'h2);
        chk("rxvec", 1, receive_vector);
        // Sparse random requests, so that the lowest pending mailbox varies.
        repeat (8)
        begin
            @(posedge sys_clk);
            transmit_request_flags <= {rnd() & rnd() & rnd(), rnd() & rnd() & rnd()};
            #1;
            for (int ch = 0; ch < 2; ch++)
            begin
                v = 1'b0;
                s = 5'h0;
                for (int j = 31; j > 0; j--)
                    if (transmit_request_flags[ch * 32 + j])
                    begin
                        v = 1'b1;
                        s = j[4:0];
                    end
                chk("txsel", {v, s}, {tx_select_valid[ch], tx_select[ch*5+:5]});
            end
        end
        wr(`CMEL_ADDR_CTRL, 32'hA);
        chk("txvalid", 0, tx_select_valid[1]);
        chk("mode", 3'h5, {soft_reset_bit, combined_mode});
        end_of_test();
    end
endmodule // tb_cmel_event_logic
